// >>> hdl/lfa_top.sv
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lfa_defines.svh"

module lfa_top
  import lfa_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [31:0] gpio_in_i,
  input wire logic [7:0] src_tick_i,
  output logic [31:0] elem_out_o,
  output logic [15:0] trig_cfg_o,
  output logic irq_o
);

  localparam logic [31:0] ELEM_BASE = `LFA_ELEM_BASE;

  lfa_reg_t elem_cfg_r [32];
  lfa_reg_t clk_sel_r;
  lfa_reg_t irq_cfg0_r;
  lfa_reg_t irq_cfg1_r;
  lfa_reg_t din0_r;
  lfa_reg_t lock_r;
  logic [3:0] irq_mask_r;
  logic [3:0] irq_status;
  logic [3:0] irq_event;
  logic [3:0] irq_clr;
  logic [31:0] elem_out;
  logic [31:0] din_ext;
  logic [3:0] blk_tick;
  logic req;
  logic wr_go;
  logic locked;
  logic elem_hit;
  logic [4:0] elem_idx;
  logic [31:0] rd_nxt;
  lfa_reg_t wdat;

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  // The answer comes one cycle after the request is seen; the write lands
  // on the edge where the master samples the acknowledge.
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_go = req && wb_ack_o && wb_we_i;
  assign locked = (lock_r != `LFA_RST16);
  assign elem_hit = (wb_adr_i[31:7] == ELEM_BASE[31:7]);
  assign elem_idx = wb_adr_i[6:2];

  function automatic lfa_reg_t merge(input lfa_reg_t old,
                                     input lfa_reg_t mask);
    lfa_reg_t res;
    res = old;
    if (wb_sel_i[0]) begin
      res[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1]) begin
      res[15:8] = wb_dat_i[15:8];
    end
    return res & mask;
  endfunction

  assign wdat = wb_dat_i[15:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= req && !wb_ack_o;
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (elem_hit) begin
      rd_nxt[15:0] = elem_cfg_r[elem_idx];
    end else begin
      unique case (wb_adr_i)
        `LFA_CLK_ADR: rd_nxt[15:0] = clk_sel_r;
        `LFA_IRQ0_ADR: rd_nxt[15:0] = irq_cfg0_r;
        `LFA_IRQ1_ADR: rd_nxt[15:0] = irq_cfg1_r;
        `LFA_ADC_ADR: rd_nxt[15:0] = trig_cfg_o;
        `LFA_DIN0_ADR: rd_nxt[15:0] = din0_r;
        `LFA_DOUT0_ADR: rd_nxt[15:0] = elem_out[15:0];
        `LFA_DOUT1_ADR: rd_nxt[15:0] = elem_out[31:16];
        `LFA_LOCK_ADR: rd_nxt[15:0] = lock_r;
        `LFA_STAT_ADR: rd_nxt[3:0] = irq_status;
        `LFA_MASK_ADR: rd_nxt[3:0] = irq_mask_r;
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i && req && !wb_ack_o) begin
      wb_dat_o <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  generate
    for (genvar e = 0; e < 32; e++) begin : g_cfg
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          elem_cfg_r[e] <= `LFA_RST16;
        end else if (ce_i && wr_go && elem_hit && !locked &&
                     elem_idx == 5'(e)) begin
          elem_cfg_r[e] <= merge(elem_cfg_r[e], `LFA_ELEM_MASK);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_sel_r <= `LFA_RST16;
      irq_cfg0_r <= `LFA_RST16;
      irq_cfg1_r <= `LFA_RST16;
      din0_r <= `LFA_RST16;
    end else if (ce_i && wr_go && !locked) begin
      unique case (wb_adr_i)
        `LFA_CLK_ADR: clk_sel_r <= merge(clk_sel_r, `LFA_CLK_MASK);
        `LFA_IRQ0_ADR: irq_cfg0_r <= merge(irq_cfg0_r, `LFA_IRQ_MASK);
        `LFA_IRQ1_ADR: irq_cfg1_r <= merge(irq_cfg1_r, `LFA_IRQ_MASK);
        `LFA_DIN0_ADR: din0_r <= merge(din0_r, 16'hFFFF);
        default: begin
        end
      endcase
    end
  end

  // The trigger setting is not covered by the lock on purpose.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_cfg_o <= `LFA_RST16;
    end else if (ce_i && wr_go && wb_adr_i == `LFA_ADC_ADR) begin
      trig_cfg_o <= merge(trig_cfg_o, 16'hFFFF);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_r <= `LFA_RST16;
    end else if (ce_i && wr_go && wb_adr_i == `LFA_LOCK_ADR && !locked) begin
      lock_r <= merge(16'h0000, 16'hFFFF);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= `LFA_RST4;
    end else if (ce_i && wr_go && wb_adr_i == `LFA_MASK_ADR &&
                 wb_sel_i[0]) begin
      irq_mask_r <= wdat[3:0];
    end
  end

  assign irq_clr = (wr_go && wb_adr_i == `LFA_STAT_ADR && wb_sel_i[0]) ?
                   wdat[3:0] : 4'h0;

  // ----------------------------------------------------------------------
  // Fabric
  // ----------------------------------------------------------------------
  // Bypassed elements can form combinational loops through feedback;
  // software must avoid such loops, the fabric does not break them.
  generate
    for (genvar b = 0; b < 4; b++) begin : g_blk
      lfa_clk_src_t sel;
      assign sel = lfa_clk_src_t'(clk_sel_r[b*4 +: 3]);
      // Other clock sources arrive as one-cycle ticks of the bus clock.
      assign blk_tick[b] = src_tick_i[sel] || (sel == LFA_SRC_BUS);
    end
  endgenerate

  assign din_ext = {16'h0000, din0_r};

  generate
    for (genvar g = 0; g < 32; g++) begin : g_elem
      localparam int BLK = g / 8;
      localparam int PREV = ((BLK + 3) % 4) * 8 + 7;
      lfa_element #(
        .IDX(g)
      ) u_elem (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tick_i(blk_tick[BLK]),
        .cfg_i(elem_cfg_r[g][10:0]),
        .blk_i(elem_out[BLK*8 +: 8]),
        .chain_i(elem_out[PREV]),
        .din_i(din_ext[g]),
        .gpio_i(gpio_in_i[g]),
        .out_o(elem_out[g])
      );
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      elem_out_o <= 32'h0000_0000;
    end else if (ce_i) begin
      elem_out_o <= elem_out;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  assign irq_event[0] = irq_cfg0_r[`LFA_EN_BIT] &&
                        elem_out[{1'b0, irq_cfg0_r[3:0]}];
  assign irq_event[1] = irq_cfg0_r[`LFA_EN_BIT + 8] &&
                        elem_out[{1'b0, irq_cfg0_r[11:8]}];
  assign irq_event[2] = irq_cfg1_r[`LFA_EN_BIT] &&
                        elem_out[{1'b1, irq_cfg1_r[3:0]}];
  assign irq_event[3] = irq_cfg1_r[`LFA_EN_BIT + 8] &&
                        elem_out[{1'b1, irq_cfg1_r[11:8]}];

  lfa_irq u_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .event_i(irq_event),
    .clr_i(irq_clr),
    .mask_i(irq_mask_r),
    .status_o(irq_status),
    .irq_o(irq_o)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_elem_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_go && elem_hit && !locked && wb_sel_i == 4'hF)
    |=> elem_cfg_r[$past(elem_idx)] ==
        ($past(wdat) & `LFA_ELEM_MASK))
    else $error("element register did not take write");
  chk_lock_once: assert property (@(posedge clk_i) disable iff (rst_i)
    locked |=> $stable(lock_r))
    else $error("lock register changed after being set");
  chk_lock_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    locked |=> $stable(clk_sel_r) && $stable(din0_r) &&
               $stable(irq_cfg0_r) && $stable(irq_cfg1_r))
    else $error("locked configuration changed");
  chk_dout_map: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && req && !wb_ack_o && wb_adr_i == `LFA_DOUT1_ADR)
    |=> wb_dat_o == {16'h0000, $past(elem_out[31:16])})
    else $error("upper output register read wrong");
  chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held for two cycles");
  chk_bus_tick: assert property (@(posedge clk_i) disable iff (rst_i)
    (clk_sel_r[2:0] == `LFA_CLK_BUS) |-> blk_tick[0])
    else $error("bus clock code does not tick block");

endmodule

`default_nettype wire

// >>> hdl/lfa_defines.svh
`ifndef LFA_DEFINES_SVH
`define LFA_DEFINES_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define LFA_ELEM_BASE 32'h4000_5800
`define LFA_CLK_ADR 32'h4000_5880
`define LFA_IRQ0_ADR 32'h4000_5884
`define LFA_IRQ1_ADR 32'h4000_5888
`define LFA_ADC_ADR 32'h4000_588C
`define LFA_DIN0_ADR 32'h4000_5890
`define LFA_DOUT0_ADR 32'h4000_5898
`define LFA_DOUT1_ADR 32'h4000_589C
`define LFA_LOCK_ADR 32'h4000_58A0
`define LFA_STAT_ADR 32'h4000_58A4
`define LFA_MASK_ADR 32'h4000_58A8

// ----------------------------------------------------------------------
// Field positions, writable masks and reset values
// ----------------------------------------------------------------------
`define LFA_EVEN_HI 10
`define LFA_EVEN_LO 9
`define LFA_ODD_HI 8
`define LFA_ODD_LO 7
`define LFA_OPA_BIT 6
`define LFA_OPB_BIT 5
`define LFA_TBL_HI 4
`define LFA_TBL_LO 1
`define LFA_BYP_BIT 0
`define LFA_ELEM_MASK 16'h07FF
`define LFA_CLK_MASK 16'h7777
`define LFA_IRQ_MASK 16'h1F1F
`define LFA_RST16 16'h0000
`define LFA_RST4 4'h0
`define LFA_CLK_BUS 3'h3
`define LFA_EN_BIT 4

`endif

// >>> hdl/lfa_pkg.sv
package lfa_pkg;

  typedef logic [15:0] lfa_reg_t;
  typedef logic [10:0] lfa_cfg_t;

  typedef enum logic [2:0] {
    LFA_SRC_PIN0 = 3'h0,
    LFA_SRC_PIN1 = 3'h1,
    LFA_SRC_PIN2 = 3'h2,
    LFA_SRC_BUS = 3'h3,
    LFA_SRC_OSC = 3'h4,
    LFA_SRC_TMR0 = 3'h5,
    LFA_SRC_TMR2 = 3'h6,
    LFA_SRC_SLOW = 3'h7
  } lfa_clk_src_t;

endpackage

// >>> hdl/lfa_element.sv
`timescale 1ns/1ps
`default_nettype none
`include "lfa_defines.svh"

module lfa_element
  import lfa_pkg::*;
#(
  parameter int IDX = 0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire lfa_cfg_t cfg_i,
  input wire logic [7:0] blk_i,
  input wire logic chain_i,
  input wire logic din_i,
  input wire logic gpio_i,
  output logic out_o
);

  logic even_fb;
  logic odd_fb;
  logic opa;
  logic opb;
  logic lut;
  logic ff_r;
  logic [1:0] even_sel;
  logic [1:0] odd_sel;
  logic [3:0] truth_table;

  assign even_sel = cfg_i[`LFA_EVEN_HI:`LFA_EVEN_LO];
  assign odd_sel = cfg_i[`LFA_ODD_HI:`LFA_ODD_LO];
  assign truth_table = cfg_i[`LFA_TBL_HI:`LFA_TBL_LO];

  // ----------------------------------------------------------------------
  // Feedback and operand selection
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (even_sel)
      2'h0: even_fb = (IDX % 8 == 0) ? chain_i : blk_i[0];
      2'h1: even_fb = blk_i[2];
      2'h2: even_fb = blk_i[4];
      2'h3: even_fb = blk_i[6];
    endcase
  end

  assign odd_fb = blk_i[{odd_sel, 1'b1}];
  assign opa = cfg_i[`LFA_OPA_BIT] ? even_fb : din_i;
  // Upper elements have no pin input, so the select bit is ignored.
  assign opb = (IDX < 16 && cfg_i[`LFA_OPB_BIT]) ? gpio_i : odd_fb;
  assign lut = truth_table[{opa, opb}];

  // ----------------------------------------------------------------------
  // Output flip-flop
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ff_r <= 1'b0;
    end else if (ce_i && tick_i) begin
      ff_r <= lut;
    end
  end

  assign out_o = cfg_i[`LFA_BYP_BIT] ? lut : ff_r;

  chk_lut_and: assert property (@(posedge clk_i) disable iff (rst_i)
    (truth_table == 4'h8) |-> (lut == (opa & opb)))
    else $error("and code does not give a and b");
  chk_lut_xor: assert property (@(posedge clk_i) disable iff (rst_i)
    (truth_table == 4'h6) |-> (out_o == (opa ^ opb)) || !cfg_i[`LFA_BYP_BIT])
    else $error("xor code does not give a xor b");
  chk_bypass_out: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_i[`LFA_BYP_BIT] |-> out_o == lut)
    else $error("bypassed element does not show lookup result");
  chk_ff_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && tick_i && !cfg_i[`LFA_BYP_BIT]) ##1
    !$past(cfg_i[`LFA_BYP_BIT]) && !cfg_i[`LFA_BYP_BIT]
    |-> out_o == $past(lut))
    else $error("flip-flop did not take lookup result on tick");
  chk_upper_odd: assert property (@(posedge clk_i) disable iff (rst_i)
    (IDX >= 16) |-> opb == odd_fb)
    else $error("upper element took pin operand");
  chk_ring_link: assert property (@(posedge clk_i) disable iff (rst_i)
    (IDX % 8 == 0 && even_sel == 2'h0 && cfg_i[`LFA_OPA_BIT])
    |-> opa == chain_i)
    else $error("first element not fed from previous block");

endmodule

`default_nettype wire

// >>> hdl/lfa_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "lfa_defines.svh"

module lfa_irq
  import lfa_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [3:0] event_i,
  input wire logic [3:0] clr_i,
  input wire logic [3:0] mask_i,
  output logic [3:0] status_o,
  output logic irq_o
);

  logic [3:0] status_nxt;

  // A source that is still high sets its bit again at once, so a level
  // interrupt cannot be cleared away while its element stays high.
  assign status_nxt = (status_o & ~clr_i) | event_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= `LFA_RST4;
    end else if (ce_i) begin
      status_o <= status_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(status_nxt & mask_i);
    end
  end

  chk_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && (event_i & clr_i) != 4'h0)
    |=> (status_o & $past(event_i & clr_i)) == $past(event_i & clr_i))
    else $error("event lost in cycle of its clear");
  chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i ##1 ce_i |-> irq_o == |($past(status_nxt) & $past(mask_i)))
    else $error("interrupt output disagrees with masked status");

endmodule

`default_nettype wire

// >>> testbench/lfa_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module lfa_pin_model (
  input wire logic clk_i,
  input wire logic [31:0] pin_lvl_i,
  input wire logic [7:0] tick_en_i,
  output logic [31:0] gpio_o,
  output logic [7:0] tick_o
);
  // ----------------------------------------------------------------
  // Pin and clock-source model
  // ----------------------------------------------------------------
  // Levels are registered so that pins move just after an edge.
  // Enabled sources tick every other cycle, as slow clocks would.
  initial begin
    gpio_o = 32'h0000_0000;
    tick_o = 8'h00;
  end
  always @(posedge clk_i) begin
    gpio_o <= pin_lvl_i;
    tick_o <= tick_en_i & ~tick_o;
  end
endmodule

`default_nettype wire

// >>> testbench/test_programmable_logic_array.sv
`timescale 1ns/1ps
`default_nettype none
`include "lfa_defines.svh"

module test_programmable_logic_array;
  import lfa_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [31:0] wb_adr = 32'h0000_0000;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic [31:0] pin_lvl = 32'h0000_0000;
  logic ce = 1'b1;
  logic [7:0] tick_en = 8'h00;
  logic [31:0] gpio;
  logic [7:0] tick;
  logic [31:0] elem_out;
  logic [15:0] trig_cfg;
  logic irq;
  logic [31:0] q;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  localparam logic [31:0] RST_ADR [12] = '{`LFA_ELEM_BASE,
    32'h4000_587C, `LFA_CLK_ADR, `LFA_IRQ0_ADR, `LFA_IRQ1_ADR,
    `LFA_ADC_ADR, `LFA_DIN0_ADR, `LFA_DOUT0_ADR, `LFA_DOUT1_ADR,
    `LFA_LOCK_ADR, `LFA_STAT_ADR, 32'h4000_58B0};

  always #5 clk_i = ~clk_i;

  lfa_top dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .gpio_in_i(gpio),
    .src_tick_i(tick), .elem_out_o(elem_out), .trig_cfg_o(trig_cfg),
    .irq_o(irq)
  );

  lfa_pin_model far_side (
    .clk_i(clk_i), .pin_lvl_i(pin_lvl), .tick_en_i(tick_en),
    .gpio_o(gpio), .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [31:0] a,
                    input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= 4'hF;
    wb_wdat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
               exp);
    end
  endtask

  task automatic out0(input logic [31:0] a, input logic exp);
    wb(1'b0, a, 16'h0000);
    chk({31'h0, q[0]}, {31'h0, exp});
  endtask

  function automatic logic lut(input logic [3:0] t, input logic a,
                               input logic b);
    return t[{a, b}];
  endfunction

  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Whole run needs under a thousand cycles; the ceiling leaves margin.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] v;
    void'($urandom(32'h7ffc));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (RST_ADR[i]) begin
      wb(1'b0, RST_ADR[i], 16'h0000);
      chk(q, 32'h0000_0000);
    end
    wb(1'b1, 32'h4000_58B0, 16'hFFFF);
    wb(1'b0, 32'h4000_58B0, 16'h0000);
    chk(q, 32'h0000_0000);
    $display("test reset done");
    for (int n = 0; n < 32; n++) begin
      // Bypass stays off here, so random feedback cannot close a loop.
      v = 16'($urandom) & 16'hFFFE;
      wb(1'b1, `LFA_ELEM_BASE + 32'(4 * n), v);
      wb(1'b0, `LFA_ELEM_BASE + 32'(4 * n), 16'h0000);
      chk(q, {16'h0, v & `LFA_ELEM_MASK});
    end
    wb(1'b1, `LFA_CLK_ADR, 16'hFFFF);
    wb(1'b0, `LFA_CLK_ADR, 16'h0000);
    chk(q, 32'h0000_7777);
    wb(1'b1, `LFA_IRQ1_ADR, 16'hFFFF);
    wb(1'b0, `LFA_IRQ1_ADR, 16'h0000);
    chk(q, 32'h0000_1F1F);
    wb(1'b1, `LFA_IRQ1_ADR, 16'h0000);
    wb(1'b1, `LFA_CLK_ADR, 16'h0000);
    $display("test register map done");
    for (int t = 0; t < 16; t++) begin
      wb(1'b1, `LFA_ELEM_BASE, 16'h0021 | 16'(t << 1));
      for (int c = 0; c < 4; c++) begin
        pin_lvl <= {$urandom, 1'b0} | 32'(c & 1);
        wb(1'b1, `LFA_DIN0_ADR, 16'($urandom) & 16'hFFFE | 16'(c >> 1));
        out0(`LFA_DOUT0_ADR, lut(4'(t), c[1], c[0]));
      end
    end
    $display("test truth table done");
    wb(1'b1, `LFA_ELEM_BASE + 32'h4, 16'h0001);
    wb(1'b1, `LFA_ELEM_BASE + 32'h8, 16'h0001);
    wb(1'b1, `LFA_ELEM_BASE + 32'h1C, 16'h001F);
    wb(1'b1, `LFA_ELEM_BASE + 32'h7C, 16'h001F);
    wb(1'b1, `LFA_ELEM_BASE, 16'h0059);
    out0(`LFA_DOUT0_ADR, 1'b1);
    wb(1'b1, `LFA_ELEM_BASE, 16'h0259);
    out0(`LFA_DOUT0_ADR, 1'b0);
    wb(1'b1, `LFA_ELEM_BASE, 16'h0195);
    out0(`LFA_DOUT0_ADR, 1'b1);
    wb(1'b1, `LFA_ELEM_BASE, 16'h0015);
    out0(`LFA_DOUT0_ADR, 1'b0);
    wb(1'b1, `LFA_ELEM_BASE + 32'h44, 16'h001F);
    wb(1'b1, `LFA_ELEM_BASE + 32'h40, 16'h0035);
    pin_lvl <= 32'h0000_0000;
    out0(`LFA_DOUT1_ADR, 1'b1);
    $display("test feedback done");
    wb(1'b1, `LFA_ELEM_BASE, 16'h0018);
    wb(1'b1, `LFA_DIN0_ADR, 16'h0001);
    out0(`LFA_DOUT0_ADR, 1'b0);
    wb(1'b1, `LFA_CLK_ADR, 16'h0003);
    out0(`LFA_DOUT0_ADR, 1'b1);
    wb(1'b1, `LFA_ELEM_BASE, 16'h0035);
    @(posedge clk_i);
    ce <= 1'b0;
    pin_lvl <= 32'h0000_0001;
    repeat (3) @(posedge clk_i);
    chk({31'h0, elem_out[0]}, 32'h0);
    ce <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({31'h0, elem_out[0]}, 32'h1);
    pin_lvl <= 32'h0000_0000;
    $display("test flip-flop done");
    wb(1'b1, `LFA_ELEM_BASE, 16'h001F);
    wb(1'b1, `LFA_STAT_ADR, 16'h000F);
    wb(1'b1, `LFA_IRQ0_ADR, 16'h0010);
    wb(1'b0, `LFA_STAT_ADR, 16'h0000);
    chk(q, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, `LFA_MASK_ADR, 16'h0001);
    wb(1'b0, `LFA_STAT_ADR, 16'h0000);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, `LFA_ELEM_BASE, 16'h0001);
    wb(1'b1, `LFA_STAT_ADR, 16'h0001);
    wb(1'b0, `LFA_STAT_ADR, 16'h0000);
    chk(q, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    wb(1'b1, `LFA_LOCK_ADR, 16'h0001);
    wb(1'b1, `LFA_LOCK_ADR, 16'h0002);
    wb(1'b0, `LFA_LOCK_ADR, 16'h0000);
    chk(q, 32'h0000_0001);
    wb(1'b1, `LFA_ELEM_BASE, 16'h07FF);
    wb(1'b0, `LFA_ELEM_BASE, 16'h0000);
    chk(q, 32'h0000_0001);
    wb(1'b1, `LFA_DIN0_ADR, 16'h0000);
    wb(1'b0, `LFA_DIN0_ADR, 16'h0000);
    chk(q, 32'h0000_0001);
    wb(1'b1, `LFA_ADC_ADR, 16'hABCD);
    wb(1'b0, `LFA_ADC_ADR, 16'h0000);
    chk({16'h0, trig_cfg}, 32'h0000_ABCD);
    $display("test lock done");
    final_report();
  end
endmodule

`default_nettype wire
